// file: rtl/acs_pkg.sv
// Constants and types shared by the conversion sequencer
package acs_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTL0 = 8'h60;
  localparam logic [7:0] IDX_CTL1 = 8'h61;
  localparam logic [7:0] IDX_CTL2 = 8'h62;
  localparam logic [7:0] IDX_CTL3 = 8'h63;
  localparam logic [7:0] IDX_CTL4 = 8'h64;
  localparam logic [7:0] IDX_CTL5 = 8'h65;
  localparam logic [7:0] IDX_STAT1 = 8'h66;
  localparam logic [7:0] IDX_STAT2 = 8'h67;
  localparam logic [7:0] IDX_RES0 = 8'h70;
  localparam logic [7:0] IDX_RES7 = 8'h7E;
  // Field positions in power_and_irq_control
  localparam int unsigned POS_POWER_UP = 7;
  localparam int unsigned POS_FAST_CLEAR = 6;
  localparam int unsigned POS_WAIT_DISABLE = 5;
  localparam int unsigned POS_SEQ_IRQ_ENABLE = 1;
  localparam int unsigned POS_SEQ_IRQ_FLAG = 0;
  // Field positions in sequence_start_control
  localparam int unsigned POS_EIGHT_CONV = 6;
  localparam int unsigned POS_SCAN = 5;
  localparam int unsigned POS_MULTI = 4;
  // Field position in status register 1
  localparam int unsigned POS_SEQ_DONE = 7;
  // Reset values
  localparam logic [7:0] RST_CTL2 = 8'h00;
  localparam logic [1:0] RST_FREEZE = 2'h0;
  localparam logic [1:0] RST_SAMPLE = 2'h0;
  localparam logic [4:0] RST_PRESCALE = 5'h01;
  localparam logic [7:0] RST_CTL5 = 8'h00;
  // Freeze codes
  localparam logic [1:0] FRZ_FINISH = 2'h2;
  localparam logic [1:0] FRZ_NOW = 2'h3;
  // Conversion phase lengths in converter clocks
  localparam logic [5:0] CYC_INIT_SAMPLE = 6'h02;
  localparam logic [5:0] CYC_TRANSFER = 6'h04;
  localparam logic [5:0] CYC_FINAL_BASE = 6'h02;
  localparam logic [5:0] CYC_RESOLVE = 6'h0A;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_HOLD} acs_state_t;
endpackage

// file: rtl/acs_top.sv
// Conversion sequencer with AXI4-Lite register slave
// Contract
// RULE_01: Sequence holds eight conversions if eight_conv_select set, else four.
// RULE_02: Single mode sets sequence_done_flag after last conversion, then halts.
// RULE_03: Scan mode sets sequence_done_flag after first sequence, restarts forever.
// RULE_04: scan_select one repeats sequences; zero runs one sequence.
// RULE_05: channel_done_flag sets on result load, clears on result read.
// RULE_06: Writing start register starts anew, clearing all done flags; a flag set by a conversion ending in that same cycle stays set.
// RULE_07: Writing any other control register aborts; idle until next start.
// RULE_08: power_up enables converter clock and analog power; zero disables.
// RULE_09: With fast_clear, writing a result register clears its flag.
// RULE_10: Without fast_clear, status read then result read clears flag.
// RULE_11: wait_disable stops converter while processor waits.
// RULE_12: seq_irq_enable gates interrupt request from seq_irq_flag.
// RULE_13: seq_irq_flag sets at sequence end, read-only; other bits writable. The code drops writes to bits 4 to 2, which read zero.
// RULE_14: freeze_sel: continue, reserved, finish then freeze, freeze immediately.
// RULE_15: Conversion: two sample, four transfer, final sample, ten resolve clocks.
// RULE_16: sample_sel gives final sample of 2, 4, 8 or 16 clocks.
// RULE_17: Converter clock is peripheral clock over prescale plus one, halved.
// RULE_18: prescale_sel resets to one, divisor four.
// RULE_19: Software keeps converter clock 500 kHz to 2 MHz, upper codes unused.
// RULE_20: multi_channel_select converts sequential channels; else one selected channel.
// RULE_21: Channel code: 0xxx inputs, 10xx reserved, 11xx references and test.
// RULE_22: Multichannel ignores low bits, converts group ascending into results.
// RULE_23: With fast_clear, first result read clears sequence_done_flag.
// RULE_24: Results are unsigned left-justified bytes, read-only.
// RULE_25: Single channel fills results in order from result zero.
`timescale 1ns/1ps
module acs_top
  import acs_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  input  wire logic [7:0]          conv_result,
  input  wire logic                cpu_wait,
  input  wire logic                debug_active,
  output logic                     analog_power,
  output logic                     conv_clk,
  output logic [3:0]               conv_chan,
  output logic                     sample_phase,
  output logic                     resolve_phase,
  output logic                     seq_irq
);
  function automatic logic is_result(input logic [7:0] idx);
    return (idx >= IDX_RES0) && (idx <= IDX_RES7) && !idx[0];
  endfunction
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0)
      && (((i >= IDX_CTL0) && (i <= IDX_STAT2)) || is_result(i));
  endfunction

  logic             awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]       bresp_reg, rresp_reg;
  logic [31:0]      rdata_reg;
  logic             aw_got_reg, w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]       wdata_reg;
  logic             wstrb0_reg;
  logic [7:0]       ctl2_reg, ctl5_reg;
  logic [1:0]       freeze_reg, sample_reg;
  logic [4:0]       prescale_reg;
  logic             seq_flag_reg, seq_done_reg, irq_reg;
  logic [7:0]       chan_done_reg, armed_reg;
  logic [7:0]       result_reg [0:7];
  acs_state_t       state_reg;
  logic [2:0]       idx_reg;
  logic [5:0]       cnt_reg;
  logic [4:0]       pre_cnt_reg;
  logic             half_reg;
  logic [3:0]       chan_reg;
  logic             smp_ph_reg, res_ph_reg;

  logic       wr_fire, rd_fire, wr_ok, start, abort;
  logic [7:0] widx, ridx;
  logic       clk_run, tick, done, last_conv, seq_end;
  logic [5:0] total;
  logic [2:0] last_idx;
  logic [7:0] rd_byte;
  logic [7:0] res_rd, res_wr;

  assign widx = awaddr_reg[9:2];
  assign ridx = s_axi_araddr[9:2];
  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign wr_ok = wr_fire && wstrb0_reg && is_mapped(awaddr_reg);
  assign start = wr_ok && (widx == IDX_CTL5);
  assign abort = wr_ok && (widx >= IDX_CTL0) && (widx <= IDX_CTL4);

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_got_reg  <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        w_got_reg  <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (is_result(ridx)) begin
      // Result registers are plain stored bytes, never written by the bus
      rd_byte = result_reg[ridx[3:1]];
    end else begin
      case (ridx)
        IDX_CTL2:  rd_byte = {ctl2_reg[7:1], seq_flag_reg};
        IDX_CTL3:  rd_byte = {6'h00, freeze_reg};
        IDX_CTL4:  rd_byte = {1'b0, sample_reg, prescale_reg};
        IDX_CTL5:  rd_byte = {1'b0, ctl5_reg[6:0]};
        IDX_STAT1: rd_byte = {seq_done_reg, 4'h0, idx_reg};
        IDX_STAT2: rd_byte = chan_done_reg;
        default:   rd_byte = 8'h00;
      endcase
    end
  end

  // Read channel: one outstanding read, answer one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= is_mapped(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h0000_0000;
      rresp_reg   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl2_reg     <= RST_CTL2;
      freeze_reg   <= RST_FREEZE;
      sample_reg   <= RST_SAMPLE;
      // RULE_18: prescale reset value
      prescale_reg <= RST_PRESCALE;
      ctl5_reg     <= RST_CTL5;
    end else if (wr_ok) begin
      case (widx)
        // RULE_13: flag bit not writable
        IDX_CTL2: ctl2_reg <= {wdata_reg[7:5], 3'h0, wdata_reg[1], 1'b0};
        IDX_CTL3: freeze_reg <= wdata_reg[1:0];
        IDX_CTL4: begin
          sample_reg   <= wdata_reg[6:5];
          prescale_reg <= wdata_reg[4:0];
        end
        IDX_CTL5: ctl5_reg <= {1'b0, wdata_reg[6:0]};
        default: ;
      endcase
    end
  end

  // RULE_08: power gates clock; RULE_11: wait stop; RULE_14: freeze now
  assign clk_run = ctl2_reg[POS_POWER_UP]
    && !(ctl2_reg[POS_WAIT_DISABLE] && cpu_wait)
    && !(debug_active && (freeze_reg == FRZ_NOW));
  // RULE_17: divide by prescale plus one, then by two
  assign tick = clk_run && (pre_cnt_reg >= prescale_reg) && half_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_reg <= 5'h00;
      half_reg    <= 1'b0;
    end else if (clk_run) begin
      if (pre_cnt_reg >= prescale_reg) begin
        pre_cnt_reg <= 5'h00;
        half_reg    <= !half_reg;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 5'h01;
      end
    end
  end

  // RULE_15: phase order; RULE_16: final sample doubles per code
  assign total = CYC_INIT_SAMPLE + CYC_TRANSFER + (CYC_FINAL_BASE << sample_reg)
    + CYC_RESOLVE;
  // RULE_01: four or eight conversions
  assign last_idx = ctl5_reg[POS_EIGHT_CONV] ? 3'h7 : 3'h3;
  assign last_conv = (idx_reg == last_idx);
  assign done = (state_reg == ACS_CONV) && tick && (cnt_reg == total - 6'h01);
  assign seq_end = done && last_conv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ACS_IDLE;
      idx_reg   <= 3'h0;
      cnt_reg   <= 6'h00;
    end else if (start) begin
      // RULE_06: restart from first conversion
      state_reg <= ACS_CONV;
      idx_reg   <= 3'h0;
      cnt_reg   <= 6'h00;
    end else if (abort) begin
      // RULE_07: abort until next start
      state_reg <= ACS_IDLE;
      cnt_reg   <= 6'h00;
    end else begin
      case (state_reg)
        ACS_CONV: begin
          if (done) begin
            cnt_reg <= 6'h00;
            // RULE_25: results fill in order
            idx_reg <= last_conv ? 3'h0 : idx_reg + 3'h1;
            // RULE_02: single mode halts; RULE_03, RULE_04: scan repeats
            if (last_conv && !ctl5_reg[POS_SCAN]) begin
              state_reg <= ACS_IDLE;
            // RULE_14: finish then freeze
            end else if (debug_active && (freeze_reg == FRZ_FINISH)) begin
              state_reg <= ACS_HOLD;
            end
          end else if (tick) begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        ACS_HOLD: begin
          if (!(debug_active && (freeze_reg == FRZ_FINISH))) begin
            state_reg <= ACS_CONV;
          end
        end
        default: state_reg <= ACS_IDLE;
      endcase
    end
  end

  // RULE_24: unsigned left-justified byte stored as delivered
  always_ff @(posedge aclk) begin
    if (done) begin
      result_reg[idx_reg] <= conv_result;
    end
  end

  generate
    for (genvar g = 0; g < 8; g++) begin : g_flag
      assign res_rd[g] = rd_fire && is_mapped(s_axi_araddr) && (ridx == IDX_RES0 + 8'(2 * g));
      assign res_wr[g] = wr_ok && (widx == IDX_RES0 + 8'(2 * g));
    end
  endgenerate

  // RULE_05: set on load, set wins over clear
  // RULE_09: fast clear by result write
  // RULE_10: armed by status read, cleared by result read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_done_reg <= 8'h00;
      armed_reg     <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (done && (idx_reg == 3'(i))) begin
          chan_done_reg[i] <= 1'b1;
        end else if (start || (res_rd[i] && (ctl2_reg[POS_FAST_CLEAR] || armed_reg[i]))
                     || (res_wr[i] && ctl2_reg[POS_FAST_CLEAR])) begin
          chan_done_reg[i] <= 1'b0;
        end
        if (start || res_rd[i]) begin
          armed_reg[i] <= 1'b0;
        end else if (rd_fire && (ridx == IDX_STAT1 || ridx == IDX_STAT2)) begin
          armed_reg[i] <= chan_done_reg[i];
        end
      end
    end
  end

  // RULE_02: sequence done flag; RULE_23: fast clear on result read
  // RULE_13: interrupt flag set at sequence end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_done_reg <= 1'b0;
      seq_flag_reg <= 1'b0;
    end else begin
      if (seq_end) begin
        seq_done_reg <= 1'b1;
      end else if (start || ((|res_rd) && ctl2_reg[POS_FAST_CLEAR])) begin
        seq_done_reg <= 1'b0;
      end
      if (seq_end) begin
        seq_flag_reg <= 1'b1;
      end else if (start) begin
        seq_flag_reg <= 1'b0;
      end
    end
  end

  // RULE_12: enable gates request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= seq_flag_reg && ctl2_reg[POS_SEQ_IRQ_ENABLE];
    end
  end

  // RULE_20: sequential or fixed; RULE_21: four-bit code; RULE_22: group base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_reg   <= 4'h0;
      smp_ph_reg <= 1'b0;
      res_ph_reg <= 1'b0;
    end else begin
      if (!ctl5_reg[POS_MULTI]) begin
        chan_reg <= ctl5_reg[3:0];
      end else if (ctl5_reg[POS_EIGHT_CONV]) begin
        chan_reg <= {ctl5_reg[3], idx_reg};
      end else begin
        chan_reg <= {ctl5_reg[3:2], idx_reg[1:0]};
      end
      smp_ph_reg <= (state_reg == ACS_CONV) && (cnt_reg < total - CYC_RESOLVE);
      res_ph_reg <= (state_reg == ACS_CONV) && (cnt_reg >= total - CYC_RESOLVE);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign analog_power  = ctl2_reg[POS_POWER_UP];
  assign conv_clk      = half_reg;
  assign conv_chan     = chan_reg;
  assign sample_phase  = smp_ph_reg;
  assign resolve_phase = res_ph_reg;
  assign seq_irq       = irq_reg;

  default clocking def_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_div_window;
    tick && prescale_reg == 5'h01 ##1 (clk_run && prescale_reg == 5'h01)[*4];
  endsequence
  sequence s_seq_end_quiet;
    seq_end && !start && !abort;
  endsequence

  property p_seq_len;
    done && !start && !abort && (idx_reg == last_idx) |=> idx_reg == 3'h0;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence length wrong"); // RULE_01
  property p_single_halt;
    s_seq_end_quiet and !ctl5_reg[POS_SCAN] |=> state_reg == ACS_IDLE && seq_done_reg;
  endproperty
  a_single_halt: assert property (p_single_halt) else $error("single no halt"); // RULE_02
  property p_scan_go;
    s_seq_end_quiet and ctl5_reg[POS_SCAN] |=> state_reg != ACS_IDLE && seq_done_reg;
  endproperty
  a_scan_go: assert property (p_scan_go) else $error("scan stopped"); // RULE_03
  property p_ccf_set;
    done && !start |=> chan_done_reg[$past(idx_reg)];
  endproperty
  a_ccf_set: assert property (p_ccf_set) else $error("done flag not set"); // RULE_05
  property p_start_clr;
    start && !done |=> chan_done_reg == 8'h00 && !seq_done_reg && state_reg == ACS_CONV;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start no clear"); // RULE_06
  property p_abort;
    abort && !start |=> state_reg == ACS_IDLE ##1 (state_reg == ACS_IDLE || $past(start));
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored"); // RULE_07
  property p_irq;
    ##1 seq_irq == $past(seq_flag_reg && ctl2_reg[POS_SEQ_IRQ_ENABLE]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating wrong"); // RULE_12
  property p_div4;
    s_div_window |-> tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divisor not four"); // RULE_17
  property p_freeze;
    debug_active && freeze_reg == FRZ_NOW && !start && !abort |-> !tick ##1 $stable(cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("no immediate freeze"); // RULE_14
endmodule

// file: testbench/acs_core_model.sv
// Behavioural converter core facing the sequencer
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic       aclk,
  input  wire logic [3:0] conv_chan,
  input  wire logic       resolve_phase,
  input  wire logic [7:0] salt,
  output logic [7:0]      conv_result
);
  logic       hold_q;
  logic [7:0] last_q;
  always_ff @(posedge aclk) begin
    hold_q <= resolve_phase;
    last_q <= conv_result;
  end
  // unsigned byte per channel
  // Outside resolution the bus toggles, so no stale value passes
  always_comb begin
    conv_result = (resolve_phase || hold_q) ? ({conv_chan, 4'h0} ^ salt) : ~last_q;
  end
endmodule

// file: testbench/tb_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
  import acs_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd;
  logic [1:0]        bresp, rresp, rsp;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              cpu_wait = 1'b0, debug_active = 1'b0;
  logic              analog_power, conv_clk, sample_phase, resolve_phase, seq_irq;
  logic [3:0]        conv_chan;
  logic [7:0]        conv_result, c5;
  logic [7:0]        salt = 8'h00;
  logic [31:0]       seed = 32'hC11584C5;
  logic              hit;
  int                err_total = 0, n_compared = 0, k;

  always #2.5 aclk = ~aclk;

  acs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .conv_result(conv_result), .cpu_wait(cpu_wait),
    .debug_active(debug_active), .analog_power(analog_power), .conv_clk(conv_clk),
    .conv_chan(conv_chan), .sample_phase(sample_phase),
    .resolve_phase(resolve_phase), .seq_irq(seq_irq));

  acs_core_model core (.aclk(aclk), .conv_chan(conv_chan),
    .resolve_phase(resolve_phase), .salt(salt), .conv_result(conv_result));

  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    bit a, w, b;
    a = 0;
    w = 0;
    b = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= ADDR_W'({idx, 2'b00});
    wdata <= {24'h000000, d};
    while (!b) begin
      @(posedge aclk);
      if (a && w && bvalid === 1'b1) begin
        b = 1;
        rsp = bresp;
      end
      if (!a && awready === 1'b1) begin
        a = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] idx);
    bit a, b;
    a = 0;
    b = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= ADDR_W'({idx, 2'b00});
    while (!b) begin
      @(posedge aclk);
      if (a && rvalid === 1'b1) begin
        b = 1;
        rd = rdata;
        rsp = rresp;
      end
      if (!a && arready === 1'b1) begin
        a = 1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic chkr(input logic [7:0] idx, input logic [31:0] exp);
    axr(idx);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] ev(input logic [7:0] c, input int i);
    logic [3:0] ch;
    ch = !c[POS_MULTI] ? c[3:0] : c[POS_EIGHT_CONV] ? {c[3], 3'(i)} : {c[3:2], 2'(i)};
    return {24'h000000, {ch, 4'h0} ^ salt};
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic start(input logic [7:0] c);
    seed = xs(seed);
    salt <= seed[7:0];
    axw(IDX_CTL5, c);
  endtask

  function automatic logic sg(input int w);
    return w == 0 ? sample_phase : w == 1 ? resolve_phase : conv_clk;
  endfunction

  task automatic skip_to(input int w, input logic v);
    k = 0;
    while (sg(w) !== v && k < 3000) begin
      @(posedge aclk);
      k++;
    end
  endtask

  task automatic run_len(input int w, input int exp);
    int n;
    n = 0;
    while (sg(w) === 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk(n, exp);
  endtask

  task automatic wait_done;
    k = 0;
    rd = '0;
    while (rd[POS_SEQ_DONE] !== 1'b1 && k < 400) begin
      axr(IDX_STAT1);
      k++;
    end
    chk(rd[POS_SEQ_DONE], 1'b1);
  endtask

  task automatic watch(input int n);
    hit = 0;
    repeat (n) begin
      @(posedge aclk);
      if (resolve_phase === 1'b1) hit = 1;
    end
  endtask

  task automatic moved(input int n);
    logic v;
    hit = 0;
    v = conv_clk;
    repeat (n) begin
      @(posedge aclk);
      if (conv_clk !== v) hit = 1;
    end
  endtask

  task automatic stall(input bit dbg, input bit wt);
    debug_active <= dbg;
    cpu_wait <= wt;
    repeat (3) @(posedge aclk);
    moved(40);
    debug_active <= 1'b0;
    cpu_wait <= 1'b0;
  endtask

  task automatic drain(input logic [7:0] c, input bit fast);
    int n;
    logic [7:0] m;
    n = c[POS_EIGHT_CONV] ? 8 : 4;
    m = 8'((1 << n) - 1);
    chkr(IDX_STAT2, m);
    for (int i = 0; i < n; i++) begin
      chkr(8'(IDX_RES0 + 2 * i), ev(c, i));
      m[i] = 1'b0;
      chkr(IDX_STAT2, m);
    end
    axr(IDX_STAT1);
    chk(rd[POS_SEQ_DONE], !fast);
  endtask

  initial begin
    #500000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chkr(IDX_CTL2, RST_CTL2);
    chkr(IDX_CTL4, 32'h01);
    chkr(IDX_CTL5, RST_CTL5);
    chkr(IDX_STAT1, 32'h00);
    axr(8'h00);
    chk(rsp, RESP_SLVERR);
    axw(8'h00, 8'hFF);
    chk(rsp, RESP_SLVERR);
    axw(IDX_CTL2, 8'h83);
    chkr(IDX_CTL2, 32'h82);
    chk(analog_power, 1'b1);
    $display("Test reset done");
    // prescale kept in the low codes
    axw(IDX_CTL4, 8'h00);
    c5 = {5'h00, seed[2:0]};
    start(c5);
    k = 0;
    while (seq_irq !== 1'b1 && k < 2000) begin
      @(posedge aclk);
      k++;
    end
    chk(seq_irq, 1'b1);
    chkr(IDX_CTL2, 32'h83);
    chkr(IDX_RES0, ev(c5, 0));
    chkr(IDX_STAT2, 32'h0F);
    chkr(IDX_RES0, ev(c5, 0));
    chkr(IDX_STAT2, 32'h0E);
    axw(8'(IDX_RES0 + 6), 8'h00);
    chkr(IDX_STAT2, 32'h0E);
    chkr(8'(IDX_RES0 + 6), ev(c5, 3));
    chkr(IDX_STAT2, 32'h06);
    watch(200);
    chk(hit, 1'b0);
    $display("Test single done");
    axw(IDX_CTL2, 8'h80);
    c5 = 8'h50 | {5'h00, seed[5:3]};
    start(c5);
    wait_done();
    chk(seq_irq, 1'b0);
    drain(c5, 1'b0);
    axw(IDX_CTL2, 8'hC0);
    c5 = 8'h1C | {6'h00, seed[7:6]};
    start(c5);
    wait_done();
    drain(c5, 1'b1);
    start(c5);
    wait_done();
    axw(8'(IDX_RES0 + 4), 8'h00);
    chkr(IDX_STAT2, 32'h0B);
    $display("Test multi done");
    axw(IDX_CTL2, 8'h80);
    start(8'h20 | {5'h00, seed[2:0]});
    wait_done();
    watch(200);
    chk(hit, 1'b1);
    axw(IDX_CTL5, 8'h00);
    axw(IDX_CTL0, 8'h00);
    chkr(IDX_STAT1, 32'h00);
    chkr(IDX_STAT2, 32'h00);
    watch(300);
    chk(hit, 1'b0);
    $display("Test scan done");
    for (int s = 0; s < 4; s++) begin
      axw(IDX_CTL4, 8'((s << 5) | s));
      axw(IDX_CTL5, 8'h00);
      skip_to(1, 1'b1);
      skip_to(1, 1'b0);
      skip_to(0, 1'b1);
      run_len(0, (6 + (2 << s)) * 2 * (s + 1));
      skip_to(1, 1'b1);
      run_len(1, 20 * (s + 1));
      skip_to(2, 1'b0);
      skip_to(2, 1'b1);
      run_len(2, s + 1);
    end
    $display("Test timing done");
    axw(IDX_CTL3, {6'h00, FRZ_NOW});
    start(8'h20);
    stall(1'b1, 1'b0);
    chk(hit, 1'b0);
    moved(20);
    chk(hit, 1'b1);
    axw(IDX_CTL3, {6'h00, FRZ_FINISH});
    start(8'h20);
    debug_active <= 1'b1;
    watch(300);
    watch(100);
    chk(hit, 1'b0);
    debug_active <= 1'b0;
    watch(300);
    chk(hit, 1'b1);
    start(8'h20);
    stall(1'b0, 1'b1);
    chk(hit, 1'b1);
    axw(IDX_CTL2, 8'hA0);
    start(8'h20);
    stall(1'b0, 1'b1);
    chk(hit, 1'b0);
    axw(IDX_CTL2, 8'h00);
    chk(analog_power, 1'b0);
    start(8'h20);
    stall(1'b0, 1'b0);
    chk(hit, 1'b0);
    $display("Test stall done");
    final_report();
  end
endmodule
